/* File: verilog/scd_clock_delay.sv */
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module scd_clock_delay #(
    parameter int DW = scd_pkg::DELAY_W
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        sysref,
    output logic             sample_rise_en,
    output logic             sample_fall_en,
    output logic             sysref_window_x2,
    output logic             clock_invert_delay,
    output logic [DW-1:0]    coarse_applied,
    output logic [DW-1:0]    fine_applied,
    output logic [2*DW:0]    total_delay_code,
    output logic             link_timing_shift,
    output logic             sysref_capture
);

    initial begin
        if (DW != scd_pkg::DELAY_W ||
            (1 << DW) != scd_pkg::DELAY_STEPS) begin
            $error("scd_clock_delay: delay width must give 256 steps");
        end
    end

    logic          link_mode_setting;
    logic          inv_setting;
    logic [DW-1:0] coarse_delay_setting;
    logic [DW-1:0] fine_delay_setting;
    logic          delay_ramp_enable;
    logic          ramp_rate_select;
    logic          coarse_load;
    logic          ramp_busy;
    logic [DW-1:0] ramp_coarse;
    logic          sysref_q;
    logic [15:0]   sysref_count;
    logic [2*DW:0] next_total;
    logic [31:0]   next_rdata;

    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] b
    );
        hit = (a == b);
    endfunction

    assign coarse_load = reg_wr && hit(reg_addr, scd_pkg::ADDR_COARSE);

    // Mode and invert writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link_mode_setting <= scd_pkg::RST_SINGLE;
            inv_setting       <= scd_pkg::RST_INV;
        end else if (reg_wr && hit(reg_addr, scd_pkg::ADDR_MODE)) begin
            link_mode_setting <= reg_wdata[scd_pkg::MODE_SINGLE_BIT];
            inv_setting       <= reg_wdata[scd_pkg::MODE_INV_BIT];
        end
    end

    // Coarse target is the last written value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            coarse_delay_setting <= scd_pkg::RST_COARSE;
        end else if (coarse_load) begin
            coarse_delay_setting <= reg_wdata[DW-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fine_delay_setting <= scd_pkg::RST_FINE;
        end else if (reg_wr && hit(reg_addr, scd_pkg::ADDR_FINE)) begin
            fine_delay_setting <= reg_wdata[DW-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            delay_ramp_enable <= 1'b0;
            ramp_rate_select  <= 1'b0;
        end else if (reg_wr && hit(reg_addr, scd_pkg::ADDR_RAMP)) begin
            delay_ramp_enable <= reg_wdata[scd_pkg::RAMP_EN_BIT];
            ramp_rate_select  <= reg_wdata[scd_pkg::RAMP_FAST_BIT];
        end
    end

    // Ramp keeps the clock tree from glitching on big jumps
    scd_ramp #(
        .W (DW)
    ) u_ramp (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ramp_on (delay_ramp_enable),
        .fast    (ramp_rate_select),
        .load    (coarse_load),
        .target  (reg_wdata[DW-1:0]),
        .applied (ramp_coarse),
        .busy    (ramp_busy)
    );

    // Sampling edges per channel mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sample_rise_en   <= 1'b0;
            sample_fall_en   <= 1'b0;
            sysref_window_x2 <= 1'b0;
        end else begin
            sample_rise_en   <= 1'b1;
            sample_fall_en   <= link_mode_setting;
            sysref_window_x2 <= link_mode_setting;
        end
    end

    // Three stages kept apart, combined only in the code
    assign next_total = {inv_setting, ramp_coarse, fine_delay_setting};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clock_invert_delay <= scd_pkg::RST_INV;
            coarse_applied     <= scd_pkg::RST_COARSE;
            fine_applied       <= scd_pkg::RST_FINE;
            total_delay_code   <= '0;
        end else begin
            clock_invert_delay <= inv_setting;
            coarse_applied     <= ramp_coarse;
            fine_applied       <= fine_delay_setting;
            total_delay_code   <= next_total;
        end
    end

    // Warns the link side that all clocks move
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link_timing_shift <= 1'b0;
        end else begin
            link_timing_shift <= (next_total != total_delay_code);
        end
    end

    // Fixed rising-edge latch; pulse and periodic forms alike
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysref_q       <= 1'b0;
            sysref_capture <= 1'b0;
        end else begin
            sysref_q       <= sysref;
            sysref_capture <= sysref && !sysref_q;
        end
    end

    // Count wraps; software looks at differences only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysref_count <= 16'h0000;
        end else if (sysref_capture) begin
            sysref_count <= sysref_count + 16'h0001;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            scd_pkg::ADDR_MODE: begin
                next_rdata[scd_pkg::MODE_SINGLE_BIT] = link_mode_setting;
                next_rdata[scd_pkg::MODE_INV_BIT]    = inv_setting;
            end
            scd_pkg::ADDR_COARSE: begin
                next_rdata[DW-1:0] = coarse_delay_setting;
            end
            scd_pkg::ADDR_FINE: begin
                next_rdata[DW-1:0] = fine_delay_setting;
            end
            scd_pkg::ADDR_RAMP: begin
                next_rdata[scd_pkg::RAMP_EN_BIT]   = delay_ramp_enable;
                next_rdata[scd_pkg::RAMP_FAST_BIT] = ramp_rate_select;
            end
            scd_pkg::ADDR_STATUS: begin
                next_rdata[DW-1:0] = ramp_coarse;
                next_rdata[scd_pkg::STAT_BUSY_BIT] = ramp_busy;
            end
            scd_pkg::ADDR_SREF: begin
                next_rdata[15:0] = sysref_count;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_dual_rise:
    assert property (!rst && !link_mode_setting |=>
        sample_rise_en && !sample_fall_en)
        else $error("dual mode must sample rising edge only");

    a_single_both:
    assert property (link_mode_setting |=> sample_rise_en && sample_fall_en)
        else $error("single mode must sample both edges");

    a_window_double:
    assert property (##1 sysref_window_x2 == sample_fall_en)
        else $error("sysref window flag out of step");

    a_invert_follow:
    assert property (reg_wr && hit(reg_addr, scd_pkg::ADDR_MODE) |=>
        ##1 clock_invert_delay == $past(reg_wdata[1], 2))
        else $error("invert setting not applied");

    a_fine_direct:
    assert property (reg_wr && hit(reg_addr, scd_pkg::ADDR_FINE) |=>
        ##1 fine_applied == $past(reg_wdata[7:0], 2))
        else $error("fine delay not applied");

    a_total_combine:
    assert property (total_delay_code ==
        {clock_invert_delay, coarse_applied, fine_applied})
        else $error("total delay not the combination");

    a_shift_flag:
    assert property ($changed(total_delay_code) |-> link_timing_shift)
        else $error("delay change not flagged to link");

    a_sysref_edge:
    assert property (!sysref ##1 sysref |=> sysref_capture ##1 !sysref_capture)
        else $error("sysref edge not latched one cycle later");

    a_read_once:
    assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    a_rise_always:
    assert property (!rst |=> sample_rise_en)
        else $error("rising edge sampling dropped");

    a_fall_mode:
    assert property (!$past(rst) |->
        sample_fall_en == $past(link_mode_setting))
        else $error("falling edge enable not from mode");

    a_window_mode:
    assert property (!$past(rst) |->
        sysref_window_x2 == $past(link_mode_setting))
        else $error("sysref window flag not from mode");

    a_invert_stage:
    assert property (!$past(rst) |->
        clock_invert_delay == $past(inv_setting))
        else $error("invert stage not from setting");

    a_coarse_stage:
    assert property (!$past(rst) |-> coarse_applied == $past(ramp_coarse))
        else $error("coarse stage not from ramp");

    a_fine_stage:
    assert property (!$past(rst) |->
        fine_applied == $past(fine_delay_setting))
        else $error("fine stage not from setting");

    a_total_next:
    assert property (!$past(rst) |-> total_delay_code == $past(next_total))
        else $error("total delay code not the registered sum");

    a_shift_exact:
    assert property (!$past(rst) |-> link_timing_shift ==
        (total_delay_code != $past(total_delay_code)))
        else $error("link shift flag not exact");

    a_coarse_write:
    assert property (coarse_load |=>
        coarse_delay_setting == $past(reg_wdata[DW-1:0]))
        else $error("coarse target not stored");

    a_fine_write:
    assert property (reg_wr && hit(reg_addr, scd_pkg::ADDR_FINE) |=>
        fine_delay_setting == $past(reg_wdata[DW-1:0]))
        else $error("fine setting not stored");

    a_fine_alone:
    assert property (!(reg_wr && hit(reg_addr, scd_pkg::ADDR_FINE)) |=>
        $stable(fine_delay_setting))
        else $error("fine setting moved without a write");

    a_mode_alone:
    assert property (!(reg_wr && hit(reg_addr, scd_pkg::ADDR_MODE)) |=>
        $stable(inv_setting) && $stable(link_mode_setting))
        else $error("mode settings moved without a write");

    a_ramp_write:
    assert property (reg_wr && hit(reg_addr, scd_pkg::ADDR_RAMP) |=>
        delay_ramp_enable == $past(reg_wdata[scd_pkg::RAMP_EN_BIT]))
        else $error("ramp enable not stored");

    a_rate_write:
    assert property (reg_wr && hit(reg_addr, scd_pkg::ADDR_RAMP) |=>
        ramp_rate_select == $past(reg_wdata[scd_pkg::RAMP_FAST_BIT]))
        else $error("ramp rate not stored");

    a_ramp_start:
    assert property (coarse_load && delay_ramp_enable &&
        reg_wdata[DW-1:0] != ramp_coarse |=> ramp_busy)
        else $error("coarse write did not start a ramp");

    a_ramp_off_idle:
    assert property (!delay_ramp_enable |=> !ramp_busy)
        else $error("ramp running while disabled");

    a_direct_coarse:
    assert property (coarse_load && !delay_ramp_enable |=>
        ##1 coarse_applied == $past(reg_wdata[DW-1:0], 2))
        else $error("coarse not applied directly");

    a_ramp_small_step:
    assert property (ramp_busy && delay_ramp_enable |=>
        (ramp_coarse - $past(ramp_coarse) <= scd_pkg::FAST_STEP) ||
        ($past(ramp_coarse) - ramp_coarse <= scd_pkg::FAST_STEP))
        else $error("ramp jumped instead of stepping");

    a_capture_rise:
    assert property (sysref_capture && !$past(rst, 2) |->
        $past(sysref) && !$past(sysref, 2))
        else $error("capture without a sysref rising edge");

    a_count_step:
    assert property (sysref_capture |=>
        sysref_count == $past(sysref_count) + 16'h0001)
        else $error("sysref count missed a capture");

    a_count_hold:
    assert property (!sysref_capture |=> $stable(sysref_count))
        else $error("sysref count moved without a capture");

    a_read_fine:
    assert property (reg_rd && hit(reg_addr, scd_pkg::ADDR_FINE) |=>
        reg_rdata[DW-1:0] == $past(fine_delay_setting))
        else $error("fine read back wrong");

    a_read_status:
    assert property (reg_rd && hit(reg_addr, scd_pkg::ADDR_STATUS) |=>
        reg_rdata[scd_pkg::STAT_BUSY_BIT] == $past(ramp_busy))
        else $error("ramp busy read back wrong");

    a_read_count:
    assert property (reg_rd && hit(reg_addr, scd_pkg::ADDR_SREF) |=>
        reg_rdata[15:0] == $past(sysref_count))
        else $error("sysref count read back wrong");

endmodule

/* File: verilog/scd_pkg.sv */
package scd_pkg;

    localparam int DELAY_W = 8;
    localparam int DELAY_STEPS = 256;

    localparam logic [7:0] ADDR_MODE   = 8'h00;
    localparam logic [7:0] ADDR_COARSE = 8'h04;
    localparam logic [7:0] ADDR_FINE   = 8'h08;
    localparam logic [7:0] ADDR_RAMP   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SREF   = 8'h14;

    localparam int MODE_SINGLE_BIT = 0;
    localparam int MODE_INV_BIT    = 1;
    localparam int RAMP_EN_BIT     = 0;
    localparam int RAMP_FAST_BIT   = 1;
    localparam int STAT_BUSY_BIT   = 8;

    localparam logic [7:0] RST_COARSE = 8'h00;
    localparam logic [7:0] RST_FINE   = 8'h00;
    localparam logic       RST_SINGLE = 1'b0;
    localparam logic       RST_INV    = 1'b0;

    localparam logic [8:0] SLOW_PERIOD = 9'h100;
    localparam logic [8:0] FAST_PERIOD = 9'h180;
    localparam logic [7:0] SLOW_STEP   = 8'h01;
    localparam logic [7:0] FAST_STEP   = 8'h04;

    typedef enum logic {
        RAMP_IDLE,
        RAMP_RUN
    } scd_ramp_e;

endpackage

/* File: verilog/scd_ramp.sv */
`timescale 1ns/1ps
module scd_ramp #(
    parameter int W = scd_pkg::DELAY_W
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         ramp_on,
    input  wire logic         fast,
    input  wire logic         load,
    input  wire logic [W-1:0] target,
    output logic      [W-1:0] applied,
    output logic              busy
);

    initial begin
        if (W != scd_pkg::DELAY_W) begin
            $error("scd_ramp: W must equal DELAY_W");
        end
    end

    scd_pkg::scd_ramp_e state;
    logic [8:0]         cnt;
    logic [8:0]         last;
    logic [W-1:0]       step;
    logic               tick;
    logic [W-1:0]       goal;

    function automatic logic [W-1:0] toward(
        input logic [W-1:0] cur,
        input logic [W-1:0] tgt,
        input logic [W-1:0] mx
    );
        logic [W-1:0] d;
        d = (tgt > cur) ? tgt - cur : cur - tgt;
        if (d > mx) begin
            d = mx;
        end
        toward = (tgt > cur) ? cur + d : cur - d;
    endfunction

    assign last = fast ? scd_pkg::FAST_PERIOD - 9'h001
                       : scd_pkg::SLOW_PERIOD - 9'h001;
    assign step = fast ? scd_pkg::FAST_STEP : scd_pkg::SLOW_STEP;
    assign tick = (state == scd_pkg::RAMP_RUN) && (cnt >= last) && !load;
    assign busy = (state == scd_pkg::RAMP_RUN);

    // Latched so later bus traffic cannot steer the ramp
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            goal <= scd_pkg::RST_COARSE;
        end else if (load) begin
            goal <= target;
        end
    end

    // Every coarse write (load) restarts the step timer
    always_ff @(posedge sys_clk) begin
        if (rst || load || tick) begin
            cnt <= 9'h000;
        end else if (state == scd_pkg::RAMP_RUN) begin
            cnt <= cnt + 9'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= scd_pkg::RAMP_IDLE;
        end else begin
            case (state)
                scd_pkg::RAMP_IDLE: begin
                    if (load && ramp_on && target != applied) begin
                        state <= scd_pkg::RAMP_RUN;
                    end
                end
                scd_pkg::RAMP_RUN: begin
                    if (!ramp_on || (!load && applied == goal)) begin
                        state <= scd_pkg::RAMP_IDLE;
                    end
                end
                default: state <= scd_pkg::RAMP_IDLE;
            endcase
        end
    end

    // Dropping ramp enable mid-ramp snaps to target
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            applied <= scd_pkg::RST_COARSE;
        end else if (!ramp_on && load) begin
            applied <= target;
        end else if (!ramp_on && busy) begin
            applied <= goal;
        end else if (tick) begin
            applied <= toward(applied, goal, step);
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_direct_load:
    assert property (load && !ramp_on |=> applied == $past(target))
        else $error("coarse not applied directly");

    a_ramp_holds:
    assert property (busy && ramp_on && !tick |=> $stable(applied))
        else $error("coarse moved between ramp ticks");

    a_fast_bound:
    assert property (tick && fast && ramp_on |=>
        (applied - $past(applied) <= 8'h04) ||
        ($past(applied) - applied <= 8'h04))
        else $error("fast ramp step over four");

    a_slow_spacing:
    assert property ($changed(applied) && busy && ramp_on && !fast
        && !$past(load) |-> $past(cnt) == 9'h0FF)
        else $error("slow ramp step not at 256 cycles");

    a_stop_target:
    assert property (busy && applied == goal && !load |=> !busy)
        else $error("ramp did not stop at target");

endmodule

/* File: dv/scd_sysref_src.sv */
`timescale 1ns/1ps
module scd_sysref_src (
    input  wire logic       sys_clk,
    input  wire logic       fire,
    input  wire logic       periodic,
    input  wire logic [7:0] period,
    output logic            sysref,
    output int              rises
);
    int cnt = 0;
    initial sysref = 1'b0;
    initial rises = 0;
    // Period is one multiframe or a divisor of it
    always @(posedge sys_clk) begin
        // Single pulse or free-running train
        if (fire || (periodic && cnt >= period - 1)) begin
            sysref <= 1'b1;
            rises <= rises + 1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
            // Edge-aligned, two cycles high, so capture is repeatable
            if (cnt == 1) begin
                sysref <= 1'b0;
            end
        end
    end
endmodule

/* File: dv/scd_clock_delay_tb.sv */
`timescale 1ns/1ps
module scd_clock_delay_tb;
    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        fire      = 1'b0;
    logic        periodic  = 1'b0;
    logic [7:0]  period    = 8'h10;
    logic [31:0] reg_rdata;
    logic        sysref;
    logic        rise_en;
    logic        fall_en;
    logic        win_x2;
    logic        inv;
    logic [7:0]  coarse_applied;
    logic [7:0]  fine_applied;
    logic [16:0] total;
    logic        shift;
    logic        capture;
    int          rises;
    int          cap_cnt   = 0;
    int          err_count = 0;
    int          checks    = 0;
    int          n;

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    scd_clock_delay u_dut (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .sysref             (sysref),
        .sample_rise_en     (rise_en),
        .sample_fall_en     (fall_en),
        .sysref_window_x2   (win_x2),
        .clock_invert_delay (inv),
        .coarse_applied     (coarse_applied),
        .fine_applied       (fine_applied),
        .total_delay_code   (total),
        .link_timing_shift  (shift),
        .sysref_capture     (capture)
    );

    scd_sysref_src u_src (
        .sys_clk  (sys_clk),
        .fire     (fire),
        .periodic (periodic),
        .period   (period),
        .sysref   (sysref),
        .rises    (rises)
    );

    always @(posedge sys_clk) begin
        if (capture === 1'b1) begin
            cap_cnt++;
        end
    end

    task automatic end_of_test();
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Bounded wait for the applied coarse delay to move
    task automatic wait_move(output int cnt);
        logic [7:0] old;
        old = coarse_applied;
        cnt = 0;
        while (coarse_applied === old) begin
            tick(1);
            cnt++;
            if (cnt > 1000) begin
                err_count++;
                end_of_test();
            end
        end
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        check(rise_en, 1'b1);
        check(fall_en, 1'b0);
        // Unmapped 0x18 included, must read zero
        for (int i = 0; i < 7; i++) begin
            rdc(8'(i * 4), 32'h0);
        end
        wr(scd_pkg::ADDR_MODE, 32'h1);
        tick(2);
        check(fall_en, 1'b1);
        check(rise_en, 1'b1);
        check(win_x2, 1'b1);
        wr(scd_pkg::ADDR_MODE, 32'h3);
        tick(2);
        check(inv, 1'b1);
        check(total, 17'h10000);
        // Upper bits beyond the field must be dropped
        wr(scd_pkg::ADDR_FINE, 32'h1FF);
        tick(1);
        check(fine_applied, 8'hFF);
        check(total, 17'h100FF);
        check(shift, 1'b1);
        tick(1);
        check(shift, 1'b0);
        wr(scd_pkg::ADDR_COARSE, 32'h80);
        tick(1);
        check(coarse_applied, 8'h80);
        check(total, 17'h180FF);
        rdc(scd_pkg::ADDR_FINE, 32'hFF);
        // Slow ramp; rewrite after 100 cycles must restart the count
        wr(scd_pkg::ADDR_RAMP, 32'h1);
        wr(scd_pkg::ADDR_COARSE, 32'h82);
        tick(100);
        wr(scd_pkg::ADDR_COARSE, 32'h82);
        wait_move(n);
        check(32'(n >= 250 && n <= 260), 32'h1);
        check(coarse_applied, 8'h81);
        rdc(scd_pkg::ADDR_STATUS, 32'h181);
        wait_move(n);
        check(32'(n >= 245 && n <= 260), 32'h1);
        check(coarse_applied, 8'h82);
        tick(3);
        rdc(scd_pkg::ADDR_STATUS, 32'h82);
        // Fast ramp of 6 steps: 4 then a clamped 2
        wr(scd_pkg::ADDR_RAMP, 32'h3);
        wr(scd_pkg::ADDR_COARSE, 32'h88);
        wait_move(n);
        check(32'(n >= 378 && n <= 388), 32'h1);
        check(coarse_applied, 8'h86);
        wait_move(n);
        check(coarse_applied, 8'h88);
        tick(400);
        check(coarse_applied, 8'h88);
        // Dropping the enable mid-ramp snaps to the target
        wr(scd_pkg::ADDR_COARSE, 32'h10);
        wr(scd_pkg::ADDR_RAMP, 32'h0);
        tick(2);
        check(coarse_applied, 8'h10);
        // Sysref as a lone pulse, then as a periodic train
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        tick(6);
        check(cap_cnt, 1);
        periodic <= 1'b1;
        tick(100);
        periodic <= 1'b0;
        tick(20);
        check(cap_cnt, rises);
        rdc(scd_pkg::ADDR_SREF, 32'(rises));
        end_of_test();
    end
endmodule
